//--- hw/sdcu_device.sv
// device end: framing of serial writes, holding registers and command execution
// Contract
// - select 0-3 load holding nibbles low first
// - select 4-7 load address nibbles low first
// - select 8 loads command and runs it
// - select 9 loads mode; 10-15 unused
// - command 0 writes holding into port
// - command 1 programs low byte into flash
// - command 2 reads port into holding
// - command 3 reads flash byte into holding
// - command 4 reads accumulator into holding
// - commands 5,6 read pc byte, pc
// - command 7 halts, 8 restarts cpu
// - command 9 steps one cpu cycle
// - command 10 clears program counter
// - command 11 resets modules and registers
// - command 13 erases one 64-byte page
// - command 14 erases selected whole partition
// - command 15 selects auxiliary partition
// - halt returns selection to main partition
// - mode 0 four-wire, mode 1 three-wire
// - cpu wins simultaneous port access
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module sdcu_device (
  input wire logic pclk,
  input wire logic presetn,
  sdcu_link_if.device link,
  input wire logic cpu_port_busy, // cpu uses ports this cycle
  input wire logic [15:0] cpu_port_rdata, // selected port value
  input wire logic [15:0] cpu_acc, // cpu accumulator
  input wire logic [15:0] cpu_pc, // cpu program counter
  input wire logic [7:0] flash_rdata, // flash byte at flash_addr
  output logic [3:0] port_sel,
  output logic [15:0] port_wdata,
  output logic port_wr,
  output logic [11:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_wr,
  output logic page_erase,
  output logic part_erase,
  output logic aux_sel,
  output logic cpu_halt,
  output logic cpu_step,
  output logic pc_clear,
  output logic module_reset,
  output logic three_wire,
  output logic [15:0] data_holding,
  output logic [15:0] port_flash_address,
  output logic [3:0] command_code,
  output logic [3:0] interface_mode
);
  // synchronisers for the link pins
  logic [1:0] sclk_s_r, cs_s_r, din_s_r;
  logic sclk_d_r; // previous synchronised sclk
  logic [2:0] bit_cnt_r; // bits in the current frame
  logic [7:0] shift_r; // select and nibble being shifted
  logic frame_done; // eighth bit captured
  logic [3:0] sel; // completed select code
  logic [3:0] nib; // completed nibble
  logic cmd_go_r; // command loaded last cycle
  logic port_rd_pend_r; // port read waiting on cpu
  logic port_wr_pend_r; // port write waiting on cpu

  // two flops on every pin before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      din_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], link.sclk};
      cs_s_r <= {cs_s_r[0], link.cs_n};
      din_s_r <= {din_s_r[0], link.serial_data_in};
    end
  end

  // edge memory reads only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s_r[1];
    end
  end

  // shift on rising link clock; frame restarts whenever select is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
    end else if (cs_s_r[1]) begin
      bit_cnt_r <= 3'h0;
    end else if (sclk_s_r[1] && !sclk_d_r) begin
      shift_r <= {shift_r[6:0], din_s_r[1]};
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // a frame counts only when all eight bits arrived
  assign frame_done = !cs_s_r[1] && sclk_s_r[1] && !sclk_d_r
    && (bit_cnt_r == 3'(sdcu_pkg::FRAME_LAST));
  assign sel = shift_r[6:3];
  assign nib = {shift_r[2:0], din_s_r[1]};

  // nibble writes into the holding registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_flash_address <= 16'h0000;
      command_code <= sdcu_pkg::CMD_NOP; // idle with no operation pending
      interface_mode <= 4'h0;
      cmd_go_r <= 1'b0;
    end else begin
      cmd_go_r <= 1'b0;
      if (frame_done) begin
        if (sel >= sdcu_pkg::SEL_ADDR0 && sel <= sdcu_pkg::SEL_ADDR3) begin
          port_flash_address[4*sel[1:0] +: 4] <= nib;
        end else if (sel == sdcu_pkg::SEL_CMD) begin
          command_code <= nib;
          cmd_go_r <= 1'b1;
        end else if (sel == sdcu_pkg::SEL_MODE) begin
          interface_mode <= nib;
        end
        // other codes fall through untouched
      end
    end
  end

  // mode decode: only value one gives shared pins
  assign three_wire = (interface_mode == sdcu_pkg::MODE_3WIRE);

  // holding register: nibble writes and command read-backs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_holding <= 16'h0000;
    end else if (frame_done && sel <= sdcu_pkg::SEL_DATA3) begin
      data_holding[4*sel[1:0] +: 4] <= nib;
    end else if (port_rd_pend_r && !cpu_port_busy) begin
      data_holding <= cpu_port_rdata;
    end else if (cmd_go_r) begin
      unique case (command_code)
        sdcu_pkg::CMD_FLASH_RD: data_holding[7:0] <= flash_rdata;
        sdcu_pkg::CMD_ACC_RD: data_holding <= cpu_acc;
        sdcu_pkg::CMD_PCBYTE_RD: data_holding[7:0] <= flash_rdata;
        sdcu_pkg::CMD_PC_RD: data_holding <= cpu_pc;
        default: data_holding <= data_holding;
      endcase
    end
  end

  // port accesses wait while the cpu owns the ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_rd_pend_r <= 1'b0;
      port_wr_pend_r <= 1'b0;
    end else begin
      if (cmd_go_r && command_code == sdcu_pkg::CMD_PORT_RD) begin
        port_rd_pend_r <= 1'b1;
      end else if (!cpu_port_busy) begin
        port_rd_pend_r <= 1'b0;
      end
      if (cmd_go_r && command_code == sdcu_pkg::CMD_PORT_WR) begin
        port_wr_pend_r <= 1'b1;
      end else if (!cpu_port_busy) begin
        port_wr_pend_r <= 1'b0;
      end
    end
  end

  // port write strobe lands only in a cycle the cpu leaves free
  assign port_wr = port_wr_pend_r && !cpu_port_busy;
  assign port_sel = port_flash_address[3:0];
  assign port_wdata = data_holding;

  // flash address: pc for the pc-byte read, else address register
  assign flash_addr = (command_code == sdcu_pkg::CMD_PCBYTE_RD)
    ? cpu_pc[11:0] : port_flash_address[11:0];
  assign flash_wdata = data_holding[7:0];

  // one-cycle command strobes; step fires only while cpu_halt is set, the others are not gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wr <= 1'b0;
      page_erase <= 1'b0;
      part_erase <= 1'b0;
      cpu_step <= 1'b0;
      pc_clear <= 1'b0;
      module_reset <= 1'b0;
    end else begin
      flash_wr <= cmd_go_r && command_code == sdcu_pkg::CMD_FLASH_WR;
      page_erase <= cmd_go_r && command_code == sdcu_pkg::CMD_PAGE_ERASE;
      part_erase <= cmd_go_r && command_code == sdcu_pkg::CMD_PART_ERASE;
      cpu_step <= cmd_go_r && command_code == sdcu_pkg::CMD_STEP && cpu_halt;
      pc_clear <= cmd_go_r && command_code == sdcu_pkg::CMD_PC_CLR;
      module_reset <= cmd_go_r && command_code == sdcu_pkg::CMD_MOD_RST;
    end
  end

  // cpu halt flag and partition selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt <= 1'b0;
      aux_sel <= 1'b0;
    end else if (cmd_go_r) begin
      if (command_code == sdcu_pkg::CMD_HALT) begin
        cpu_halt <= 1'b1;
        aux_sel <= 1'b0;
      end else if (command_code == sdcu_pkg::CMD_START) begin
        cpu_halt <= 1'b0;
      end else if (command_code == sdcu_pkg::CMD_AUX_SEL) begin
        aux_sel <= 1'b1;
      end
    end
  end
endmodule : sdcu_device

//--- shared/sdcu_pkg.sv
// package: select codes, commands, link framing and apb map for the serial debug command unit
package sdcu_pkg;
  // nibble select codes
  localparam logic [3:0] SEL_DATA0 = 4'h0;
  localparam logic [3:0] SEL_DATA3 = 4'h3;
  localparam logic [3:0] SEL_ADDR0 = 4'h4;
  localparam logic [3:0] SEL_ADDR3 = 4'h7;
  localparam logic [3:0] SEL_CMD = 4'h8;
  localparam logic [3:0] SEL_MODE = 4'h9;
  // command codes
  typedef enum logic [3:0] {
    CMD_PORT_WR = 4'h0, CMD_FLASH_WR = 4'h1, CMD_PORT_RD = 4'h2, CMD_FLASH_RD = 4'h3,
    CMD_ACC_RD = 4'h4, CMD_PCBYTE_RD = 4'h5, CMD_PC_RD = 4'h6, CMD_HALT = 4'h7,
    CMD_START = 4'h8, CMD_STEP = 4'h9, CMD_PC_CLR = 4'ha, CMD_MOD_RST = 4'hb,
    CMD_NOP = 4'hc, CMD_PAGE_ERASE = 4'hd, CMD_PART_ERASE = 4'he, CMD_AUX_SEL = 4'hf
  } sdcu_cmd_t;
  // interface mode values
  localparam logic [3:0] MODE_4WIRE = 4'h0;
  localparam logic [3:0] MODE_3WIRE = 4'h1;
  // flash geometry
  localparam int FLASH_ADDR_W = 12;
  localparam int PAGE_LSB = 6;
  localparam int MAIN_SIZE = 4096;
  localparam int AUX_SIZE = 128;
  // link framing: one frame is 8 bits, select msb first then nibble
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] FRAME_LAST = 4'h7;
  // host link clock half period in pclk cycles (160 ns at 40 ns pclk, 320 ns full period)
  localparam int LINK_PERIOD_NS = 320;
  localparam int PCLK_NS = 40;
  localparam logic [3:0] LINK_HALF = 4'((LINK_PERIOD_NS / PCLK_NS) / 2);
  // host apb register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // ctrl fields: [3:0] nibble, [7:4] select, [8] go (self clearing)
  localparam int CTRL_NIB_LSB = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_GO_BIT = 8;
  // status field: [0] busy
  localparam int STAT_BUSY_BIT = 0;
endpackage : sdcu_pkg

//--- shared/sdcu_link_if.sv
// interface: serial link between the host end and the device end
`timescale 1ns/1ps
interface sdcu_link_if;
  logic sclk; // link clock, made by the host
  logic cs_n; // frame select, active low
  logic serial_data_in; // host to device data
  modport host (output sclk, output cs_n, output serial_data_in);
  modport device (input sclk, input cs_n, input serial_data_in);
endinterface : sdcu_link_if

//--- hw/sdcu_host.sv
// host end: apb registers that send one select/nibble frame per order
`timescale 1ns/1ps
module sdcu_host (
  input wire logic pclk,
  input wire logic presetn,
  sdcu_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {SDCU_IDLE, SDCU_LOW, SDCU_HIGH, SDCU_END} sdcu_hstate_t;
  sdcu_hstate_t state_r; // frame sequencer
  logic [7:0] frame_r; // select then nibble, msb first
  logic [2:0] bit_r; // bits still to send minus one
  logic [3:0] div_r; // half period divider
  logic half_tick; // divider wrapped
  logic wr_ctrl; // apb write to ctrl with go
  logic busy; // frame in progress

  assign busy = (state_r != SDCU_IDLE);
  assign half_tick = (div_r == sdcu_pkg::LINK_HALF - 4'h1);
  // zero-wait slave; unmapped offsets raise pslverr
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != sdcu_pkg::OFS_CTRL
    && paddr != sdcu_pkg::OFS_STATUS;
  // the select/nibble pair goes out only once per frame; writes while busy are dropped
  assign wr_ctrl = psel && penable && pwrite && paddr == sdcu_pkg::OFS_CTRL
    && pwdata[sdcu_pkg::CTRL_GO_BIT] && !busy;

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= (paddr == sdcu_pkg::OFS_STATUS) ? {31'h0, busy}
        : (paddr == sdcu_pkg::OFS_CTRL) ? {24'h0, frame_r} : 32'h00000000;
    end
  end

  // divider for the link clock, runs only during a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 4'h0;
    end else if (!busy || half_tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // frame sequencer: data set while sclk low, device samples rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SDCU_IDLE;
      frame_r <= 8'h00;
      bit_r <= 3'h0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.serial_data_in <= 1'b0;
    end else begin
      unique case (state_r)
        SDCU_IDLE: begin
          if (wr_ctrl) begin
            frame_r <= {pwdata[sdcu_pkg::CTRL_SEL_LSB +: 4], pwdata[sdcu_pkg::CTRL_NIB_LSB +: 4]};
            bit_r <= 3'h7;
            link.cs_n <= 1'b0;
            link.serial_data_in <= pwdata[sdcu_pkg::CTRL_SEL_LSB + 3];
            state_r <= SDCU_LOW;
          end
        end
        SDCU_LOW: begin
          if (half_tick) begin
            link.sclk <= 1'b1;
            state_r <= SDCU_HIGH;
          end
        end
        SDCU_HIGH: begin
          if (half_tick) begin
            link.sclk <= 1'b0;
            if (bit_r == 3'h0) begin
              state_r <= SDCU_END;
            end else begin
              bit_r <= bit_r - 3'h1;
              link.serial_data_in <= frame_r[bit_r - 3'h1];
              state_r <= SDCU_LOW;
            end
          end
        end
        SDCU_END: begin
          if (half_tick) begin
            link.cs_n <= 1'b1;
            state_r <= SDCU_IDLE;
          end
        end
      endcase
    end
  end
endmodule : sdcu_host

//--- verification/sdcu_link_sva.sv
// checker: link framing and device output relations of the command unit
`timescale 1ns/1ps
module sdcu_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic cpu_port_busy,
  input wire logic port_wr,
  input wire logic [11:0] flash_addr,
  input wire logic flash_wr,
  input wire logic page_erase,
  input wire logic part_erase,
  input wire logic aux_sel,
  input wire logic cpu_halt,
  input wire logic cpu_step,
  input wire logic three_wire,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] port_flash_address,
  input wire logic [3:0] command_code,
  input wire logic [3:0] interface_mode
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_LINK_IDLE: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  AST_CPU_FIRST: assert property (port_wr |-> !cpu_port_busy)
    else $error("port written while cpu owns the ports");
  AST_MODE_WIRES: assert property (three_wire == (interface_mode == 4'h1))
    else $error("wire mode does not follow mode register");
  AST_FLASH_ADDR: assert property (flash_addr == ((command_code == 4'h5) ? cpu_pc[11:0]
    : port_flash_address[11:0])) else $error("flash address source wrong");
  AST_HALT_MAIN: assert property (($changed(command_code) && command_code == 4'h7)
    |-> ##1 (cpu_halt && !aux_sel)) else $error("halt left the auxiliary partition selected");
  AST_STEP_ONE: assert property (cpu_step |-> cpu_halt ##1 !cpu_step)
    else $error("step while running or longer than one cycle");
  AST_FRAME_ONLY: assert property ((cs_n && $past(cs_n)) |-> $stable(port_flash_address)
    && $stable(command_code) && $stable(interface_mode)) else $error("register moved between frames");
  AST_FLASH_PROG: assert property (($changed(command_code) && command_code == 4'h1)
    |-> ##[1:2] flash_wr) else $error("flash program pulse missing");
  AST_PAGE_ERASE: assert property (($changed(command_code) && command_code == 4'hd)
    |-> ##[1:2] page_erase) else $error("page erase pulse missing");
  AST_PART_ERASE: assert property (($changed(command_code) && command_code == 4'he)
    |-> ##[1:2] part_erase) else $error("partition erase pulse missing");
  // main scenarios reached
  cover property (cpu_step);
  cover property (port_wr);
  cover property (three_wire);
endmodule : sdcu_link_sva

//--- verification/test_serial_debug_command_unit.sv
// testbench: apb orders through the host end, checks of the device end registers
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module test_serial_debug_command_unit;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, rb, seed = 32'h000065b8;
  logic cpu_port_busy = 1'b0, port_wr, flash_wr, page_erase, part_erase, aux_sel, cpu_halt;
  logic cpu_step, pc_clear, module_reset, three_wire;
  logic [15:0] cpu_port_rdata = 16'h0, cpu_acc = 16'h0, cpu_pc = 16'h0, port_wdata;
  logic [15:0] data_holding, port_flash_address, m_dh = 16'h0, m_pfa = 16'h0;
  logic [7:0] flash_rdata = 8'h0, flash_wdata;
  logic [11:0] flash_addr;
  logic [3:0] port_sel, command_code, interface_mode, m_cmd = 4'hc, m_mode = 4'h0;
  logic m_halt = 1'b0, m_aux = 1'b0, cs_q = 1'b1;
  logic [6:0] seen = 7'h00; // strobes seen since the current frame opened
  logic [48:0] exp_q[$];
  logic [48:0] e;
  logic [3:0] cmds[18] = '{4'h7, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9,
    4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h7, 4'h8, 4'h9};
  int errors = 0, num_checks = 0, cycles = 0;
  sdcu_link_if link();
  sdcu_host i_sdcu_host (.pclk, .presetn, .link(link), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  sdcu_device i_sdcu_device (.pclk, .presetn, .link(link), .cpu_port_busy, .cpu_port_rdata,
    .cpu_acc, .cpu_pc, .flash_rdata, .port_sel, .port_wdata, .port_wr, .flash_addr,
    .flash_wdata, .flash_wr, .page_erase, .part_erase, .aux_sel, .cpu_halt, .cpu_step,
    .pc_clear, .module_reset, .three_wire, .data_holding, .port_flash_address,
    .command_code, .interface_mode);
  sdcu_link_sva i_sdcu_link_sva (.pclk, .presetn, .sclk(link.sclk), .cs_n(link.cs_n),
    .cpu_port_busy, .port_wr, .flash_addr, .flash_wr, .page_erase, .part_erase, .aux_sel,
    .cpu_halt, .cpu_step, .three_wire, .cpu_pc, .port_flash_address, .command_code,
    .interface_mode);
  // 25 mhz bus clock
  always #20 pclk = ~pclk;
  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // cpu contends for the ports in short bursts, only inside frames
  always @(posedge pclk) begin
    rb = rnd();
    cpu_port_busy <= !link.cs_n && rb[3] && rb[9];
  end
  // hang guard, well above the roughly 13000 cycles of the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      stop_test();
    end
  end
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives a strobe twice in one step
    @(posedge pclk);
  endtask : apb
  // one select/nibble frame: model update, expectation note, wait for idle
  task automatic frame(input logic [3:0] s, input logic [3:0] v);
    logic [31:0] rd;
    logic [6:0] p; // expected strobes: port, flash, page, part, step, pc clear, module reset
    p = 7'h00;
    if (s < 4'h4) m_dh[s[1:0]*4 +: 4] = v;
    else if (s < 4'h8) m_pfa[s[1:0]*4 +: 4] = v;
    else if (s == 4'h9) m_mode = v;
    else if (s == 4'h8) begin
      m_cmd = v;
      case (v)
        4'h2: m_dh = cpu_port_rdata;
        4'h3, 4'h5: m_dh[7:0] = flash_rdata;
        4'h4: m_dh = cpu_acc;
        4'h6: m_dh = cpu_pc;
        4'h7: {m_halt, m_aux} = 2'b10;
        4'h8: m_halt = 1'b0;
        4'hf: m_aux = 1'b1;
        4'h0: p[6] = 1'b1;
        4'h1: p[5] = 1'b1;
        4'h9: p[2] = m_halt;
        4'ha: p[1] = 1'b1;
        4'hb: p[0] = 1'b1;
        4'hd: p[4] = 1'b1;
        4'he: p[3] = 1'b1;
        default: ;
      endcase
    end
    exp_q.push_back({p, m_dh, m_pfa, m_cmd, m_mode, m_halt, m_aux});
    apb(1'b1, 8'h00, {23'h0, 1'b1, s, v}, rd);
    @(posedge pclk);
    rd = 32'h1;
    // the wait ends when the status busy bit reads zero; the hang guard covers a stuck frame
    while (rd[0] !== 1'b0) begin
      apb(1'b0, 8'h04, 32'h0, rd);
    end
  endtask : frame
  // monitor: registers settled a few cycles after the frame ends
  always @(posedge link.cs_n) begin
    if (presetn === 1'b1 && exp_q.size() > 0) begin
      repeat (4) @(posedge pclk);
      e = exp_q.pop_front();
      `CHK(data_holding, e[41:26], "holding")
      `CHK({port_flash_address, command_code, interface_mode}, e[25:2], "addr cmd mode")
      `CHK({cpu_halt, aux_sel}, e[1:0], "halt aux")
      `CHK(seen, e[48:42], "command strobes")
      `CHK({port_sel, port_wdata}, {e[13:10], e[41:26]}, "port out")
      `CHK(flash_wdata, e[33:26], "flash data")
    end
  end
  // strobe watcher: sticky per frame, cleared when the next frame opens
  always @(posedge pclk) begin
    cs_q <= link.cs_n;
    if (!link.cs_n && cs_q) begin
      seen <= 7'h00;
    end else begin
      seen <= seen | {port_wr, flash_wr, page_erase, part_erase,
        cpu_step, pc_clear, module_reset};
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 8'h10, 32'h1ff, r);
    `CHK(last_err, 1'b1, "unmapped not refused")
    // every select code, the unused ones too
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      frame(4'(i), (i == 8) ? 4'hc : r[3:0]);
    end
    apb(1'b0, 8'h00, 32'h0, r);
    `CHK(r[7:4], 4'hf, "ctrl readback")
    frame(4'h9, 4'h1);
    // every command, with fresh operands and cpu values
    foreach (cmds[k]) begin
      for (int j = 0; j < 8; j++) begin
        r = rnd();
        frame(4'(j), r[3:0]);
      end
      r = rnd();
      cpu_port_rdata <= r[15:0];
      cpu_acc <= r[31:16];
      r = rnd();
      cpu_pc <= r[15:0];
      flash_rdata <= r[23:16];
      @(posedge pclk);
      frame(4'h8, cmds[k]);
    end
    repeat (8) @(posedge pclk);
    stop_test();
  end
endmodule : test_serial_debug_command_unit
